// ---- hdl/smps_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module smps_sequencer
(
	// clock from free-running oscillator, reset
	input wire logic clk_sys,
	input wire logic resetn,
	// sleep request pin
	input wire logic sleep_req,
	// delay settings in cycles
	input wire logic [5:0] pad_off_delay,
	input wire logic [5:0] clock_off_delay,
	input wire logic [5:0] clock_on_delay,
	input wire logic [5:0] pad_on_delay,
	// status
	output logic sleep_status,
	// power controls
	output logic io_enable,
	output logic [15:0] clk_enable,
	// gpio pad (value and output enable)
	output logic [3:0] gpio_pad_out,
	output logic [3:0] gpio_pad_oe,
	// user counter
	output logic [7:0] cnt_value,
	output logic [7:0] cnt_sleep_enter,
	output logic [7:0] cnt_sleep_exit
);
	logic rst_s1_r, rst_s2_r, req_s1_r, req_s2_r, frozen_r;
	smps_pkg::smps_state_e state_r;
	logic [5:0] dly_r;
	logic [1:0] ramp_r;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_s2_r);
	// clamp a setting to its minimum
	function automatic logic [5:0] clamp(input logic [5:0] v,
		input logic [5:0] mn);
		clamp = (v < mn) ? mn : v;
	endfunction
	// reset release through two flops
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			{rst_s2_r, rst_s1_r} <= 2'b00;
		else
			{rst_s2_r, rst_s1_r} <= {rst_s1_r, 1'b1};
	end
	// request synchroniser, clk_sys never gated
	always_ff @(posedge clk_sys or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
			{req_s2_r, req_s1_r} <= 2'b00;
		else
			{req_s2_r, req_s1_r} <= {req_s1_r, sleep_req};
	end
	// sequencer: state, delay counter, ramp step
	always_ff @(posedge clk_sys or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
		begin
			state_r <= smps_pkg::SMPS_AWAKE;
			dly_r <= '0;
			ramp_r <= '0;
		end
		else
		begin
			case (state_r)
				smps_pkg::SMPS_AWAKE:
					if (req_s2_r)
					begin
						state_r <= smps_pkg::SMPS_PAD_OFF;
						dly_r <= 6'h01;
					end
				smps_pkg::SMPS_PAD_OFF:
				begin
					dly_r <= dly_r + 6'h01;
					if (dly_r >= clamp(pad_off_delay,
						smps_pkg::PAD_OFF_DELAY_MIN))
					begin
						state_r <= smps_pkg::SMPS_CLK_OFF;
						dly_r <= 6'h01;
					end
				end
				smps_pkg::SMPS_CLK_OFF:
				begin
					if (dly_r >= clamp(clock_off_delay,
						smps_pkg::CLOCK_OFF_DELAY_MIN))
					begin
						ramp_r <= ramp_r + 2'h1;
						if (ramp_r == 2'(smps_pkg::RAMP_STEPS - 1))
						begin
							state_r <= smps_pkg::SMPS_SLEEP;
							ramp_r <= '0;
						end
					end
					else
						dly_r <= dly_r + 6'h01;
				end
				smps_pkg::SMPS_SLEEP:
					if (!req_s2_r)
					begin
						state_r <= smps_pkg::SMPS_CLK_ON;
						dly_r <= 6'h01;
					end
				smps_pkg::SMPS_CLK_ON:
				begin
					if (dly_r >= clamp(clock_on_delay,
						smps_pkg::CLOCK_ON_DELAY_MIN))
					begin
						ramp_r <= ramp_r + 2'h1;
						if (ramp_r == 2'(smps_pkg::RAMP_STEPS - 1))
						begin
							state_r <= smps_pkg::SMPS_PAD_ON;
							ramp_r <= '0;
							dly_r <= 6'h01;
						end
					end
					else
						dly_r <= dly_r + 6'h01;
				end
				smps_pkg::SMPS_PAD_ON:
				begin
					dly_r <= dly_r + 6'h01;
					if (dly_r >= clamp(pad_on_delay,
						smps_pkg::PAD_ON_DELAY_MIN))
						state_r <= smps_pkg::SMPS_AWAKE;
				end
				default:
					state_r <= smps_pkg::SMPS_AWAKE;
			endcase
		end
	end
	// status flag spans whole entry to end of exit
	always_ff @(posedge clk_sys or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
			sleep_status <= 1'b0;
		else if (state_r == smps_pkg::SMPS_AWAKE && req_s2_r)
			sleep_status <= 1'b1;
		else if (state_r == smps_pkg::SMPS_PAD_ON && dly_r >=
			clamp(pad_on_delay, smps_pkg::PAD_ON_DELAY_MIN))
			sleep_status <= 1'b0;
	end
	// pad enable and pad drive
	always_ff @(posedge clk_sys or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
		begin
			io_enable <= 1'b1;
			gpio_pad_oe <= '1;
		end
		else if (state_r == smps_pkg::SMPS_PAD_OFF && dly_r >=
			clamp(pad_off_delay, smps_pkg::PAD_OFF_DELAY_MIN))
		begin
			io_enable <= 1'b0;
			gpio_pad_oe <= '0;
		end
		else if (state_r == smps_pkg::SMPS_PAD_ON && dly_r >=
			clamp(pad_on_delay, smps_pkg::PAD_ON_DELAY_MIN))
		begin
			io_enable <= 1'b1;
			gpio_pad_oe <= '1;
		end
	end
	// pad value is a fixed demo pattern
	always_ff @(posedge clk_sys or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
			gpio_pad_out <= '0;
		else
			gpio_pad_out <= smps_pkg::GPIO_VAL;
	end
	// clock enable ramp, active high per network
	always_ff @(posedge clk_sys or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
			clk_enable <= smps_pkg::CLK_EN_RST;
		else if (state_r == smps_pkg::SMPS_CLK_OFF && dly_r >=
			clamp(clock_off_delay, smps_pkg::CLOCK_OFF_DELAY_MIN))
		begin
			case (ramp_r)
				2'h0: clk_enable <= smps_pkg::RAMP_OFF_1;
				2'h1: clk_enable <= smps_pkg::RAMP_OFF_2;
				default: clk_enable <= '0;
			endcase
		end
		else if (state_r == smps_pkg::SMPS_CLK_ON && dly_r >=
			clamp(clock_on_delay, smps_pkg::CLOCK_ON_DELAY_MIN))
		begin
			case (ramp_r)
				2'h0: clk_enable <= smps_pkg::RAMP_ON_1;
				2'h1: clk_enable <= smps_pkg::RAMP_ON_2;
				default: clk_enable <= '1;
			endcase
		end
	end
	// user counter with freeze and captures
	always_ff @(posedge clk_sys or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
		begin
			cnt_value <= smps_pkg::CNT_RST;
			cnt_sleep_enter <= smps_pkg::CNT_RST;
			cnt_sleep_exit <= smps_pkg::CNT_RST;
			frozen_r <= 1'b0;
		end
		else if (state_r == smps_pkg::SMPS_AWAKE && req_s2_r && !frozen_r)
		begin
			cnt_sleep_enter <= cnt_value;
			frozen_r <= 1'b1;
		end
		else if (state_r == smps_pkg::SMPS_PAD_ON && frozen_r)
		begin
			cnt_sleep_exit <= cnt_value;
			frozen_r <= 1'b0;
		end
		else if (!frozen_r && state_r == smps_pkg::SMPS_AWAKE)
			cnt_value <= cnt_value + 8'h01;
	end
	// checks, clocked and disabled by the defaults at the top
	sequence s_enter;
		state_r == smps_pkg::SMPS_AWAKE && req_s2_r;
	endsequence
	property p_status_rise;
		s_enter |=> sleep_status && state_r == smps_pkg::SMPS_PAD_OFF;
	endproperty
	a_status_rise: assert property (p_status_rise)
		else $error("status not raised on entry");
	property p_awake_idle;
		state_r == smps_pkg::SMPS_AWAKE && !req_s2_r |->
			!sleep_status && io_enable && clk_enable == '1;
	endproperty
	a_awake_idle: assert property (p_awake_idle)
		else $error("awake outputs wrong");
	property p_sleep_off;
		state_r == smps_pkg::SMPS_SLEEP |-> clk_enable == '0 && !io_enable;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("sleep with power on");
	property p_oe_follows;
		gpio_pad_oe == {4{io_enable}};
	endproperty
	a_oe_follows: assert property (p_oe_follows)
		else $error("pad enable mismatch");
	property p_count_runs;
		state_r == smps_pkg::SMPS_AWAKE && !frozen_r && !req_s2_r |=>
			cnt_value == $past(cnt_value) + 8'h01;
	endproperty
	a_count_runs: assert property (p_count_runs)
		else $error("counter not running");
	property p_frozen;
		state_r == smps_pkg::SMPS_SLEEP |=> $stable(cnt_value);
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("counter moved asleep");
	property p_capture_eq;
		state_r == smps_pkg::SMPS_PAD_ON && frozen_r |=>
			cnt_sleep_exit == cnt_sleep_enter;
	endproperty
	a_capture_eq: assert property (p_capture_eq)
		else $error("entry and exit counts differ");
	property p_stay_sleep;
		state_r == smps_pkg::SMPS_SLEEP && req_s2_r |=>
			state_r == smps_pkg::SMPS_SLEEP;
	endproperty
	a_stay_sleep: assert property (p_stay_sleep)
		else $error("left sleep while requested");
	property p_wake;
		state_r == smps_pkg::SMPS_SLEEP && !req_s2_r |=>
			state_r == smps_pkg::SMPS_CLK_ON;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no exit on release");
endmodule
`default_nettype wire

// ---- hdl/smps_pkg.sv ----
package smps_pkg;
	// delay field width and minimum counts
	localparam int unsigned DLY_W = 6;
	localparam logic [5:0] PAD_OFF_DELAY_MIN = 6'h01;
	localparam logic [5:0] CLOCK_OFF_DELAY_MIN = 6'h0b;
	localparam logic [5:0] CLOCK_ON_DELAY_MIN = 6'h01;
	localparam logic [5:0] PAD_ON_DELAY_MIN = 6'h28;
	// clock enable vector and ramp
	localparam int unsigned CLK_EN_W = 16;
	localparam int unsigned RAMP_STEPS = 3;
	localparam logic [15:0] CLK_EN_RST = 16'hffff;
	localparam logic [15:0] RAMP_OFF_1 = 16'hfff0;
	localparam logic [15:0] RAMP_OFF_2 = 16'hff00;
	localparam logic [15:0] RAMP_ON_1 = 16'h000f;
	localparam logic [15:0] RAMP_ON_2 = 16'h00ff;
	// user counter and pads
	localparam int unsigned CNT_W = 8;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam int unsigned GPIO_W = 4;
	localparam logic [3:0] GPIO_VAL = 4'ha;
	// sequencer states
	typedef enum logic [2:0] {
		SMPS_AWAKE,
		SMPS_PAD_OFF,
		SMPS_CLK_OFF,
		SMPS_SLEEP,
		SMPS_CLK_ON,
		SMPS_PAD_ON
	} smps_state_e;
endpackage

// ---- verif/smps_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module smps_far_side
(
	// free-running clock and power controls
	input wire logic clk_sys,
	input wire logic [15:0] clk_enable,
	input wire logic [3:0] gpio_pad_out,
	input wire logic [3:0] gpio_pad_oe,
	// pad levels and ticks seen by network 0
	output logic [3:0] pad_level,
	output var bit [15:0] net_ticks // two-state, starts at zero
);
	// undriven pads sit at the weak pull-up level
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			pad_level[i] = gpio_pad_oe[i] ? gpio_pad_out[i] : 1'b1;
	end
	// gated network: logic behind it only moves while enabled
	always @(posedge clk_sys)
		if (clk_enable[0] === 1'b1)
			net_ticks <= net_ticks + 16'h0001;
endmodule
`default_nettype wire

// ---- verif/tb_sleep_mode_power_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_mode_power_sequencer;
	// stimulus and observed signals
	logic clk_sys, resetn, sleep_req, sleep_status, io_enable;
	logic [5:0] d1, d2, d3, d4;
	logic [15:0] clk_enable, net_ticks, ticks0;
	logic [3:0] gpio_pad_out, gpio_pad_oe, pad_level;
	logic [7:0] cnt_value, cnt_sleep_enter, cnt_sleep_exit, held;
	int errors, check_count, k, it;

	smps_sequencer uut (.clk_sys(clk_sys), .resetn(resetn),
		.sleep_req(sleep_req), .pad_off_delay(d1), .clock_off_delay(d2),
		.clock_on_delay(d3), .pad_on_delay(d4),
		.sleep_status(sleep_status), .io_enable(io_enable),
		.clk_enable(clk_enable), .gpio_pad_out(gpio_pad_out),
		.gpio_pad_oe(gpio_pad_oe), .cnt_value(cnt_value),
		.cnt_sleep_enter(cnt_sleep_enter), .cnt_sleep_exit(cnt_sleep_exit));
	smps_far_side far (.clk_sys(clk_sys), .clk_enable(clk_enable),
		.gpio_pad_out(gpio_pad_out), .gpio_pad_oe(gpio_pad_oe),
		.pad_level(pad_level), .net_ticks(net_ticks));

	// 40 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// value compare
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// cycle count compare
	task automatic chk_n(input int got, input int exp);
		check_count++;
		if (got != exp)
		begin
			errors++;
			$display("BAD %0t cycles %0d expected %0d", $time, got, exp);
		end
	endtask

	// delay after raising to the minimum
	function automatic int eff(input logic [5:0] d, input logic [5:0] m);
		return (d < m) ? int'(m) : int'(d);
	endfunction

	// settle just after a rising edge
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask

	// outputs held in the awake condition
	task automatic chk_awake;
		chk({14'h0, sleep_status, io_enable}, 16'h0001);
		chk(clk_enable, 16'hffff);
		chk({12'h0, gpio_pad_oe}, 16'h000f);
	endtask

	// reset for three cycles with the request held low
	task automatic do_reset;
		@(posedge clk_sys);
		resetn <= 1'b0;
		sleep_req <= 1'b0;
		#1;
		chk_awake;
		chk({cnt_value, cnt_sleep_enter}, 16'h0000);
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (5) tick;
		held = cnt_value;
		tick;
		chk({8'h0, cnt_value}, {8'h0, held + 8'h01});
	endtask

	// one full sleep entry and exit
	task automatic sleep_cycle(input int stay);
		@(posedge clk_sys);
		sleep_req <= 1'b1;
		k = 0;
		while (sleep_status !== 1'b1 && k < 9)
		begin
			tick;
			k++;
		end
		chk_n(int'(k >= 2 && k <= 4), 1);
		held = cnt_value;
		k = 0;
		while (io_enable !== 1'b0 && k < 99)
		begin
			tick;
			k++;
		end
		chk_n(k, eff(d1, 6'h01));
		chk({12'h0, pad_level}, 16'h000f);
		k = 0;
		while (clk_enable === 16'hffff && k < 99)
		begin
			tick;
			k++;
		end
		chk_n(k, eff(d2, 6'h0b));
		chk(clk_enable, 16'hfff0);
		tick;
		chk(clk_enable, 16'hff00);
		tick;
		chk(clk_enable, 16'h0000);
		ticks0 = net_ticks;
		repeat (stay) tick;
		chk(net_ticks, ticks0);
		chk({15'h0, sleep_status}, 16'h0001);
		chk({cnt_value, cnt_sleep_enter}, {held, held});
		@(posedge clk_sys);
		sleep_req <= 1'b0;
		k = 0;
		while (clk_enable === 16'h0000 && k < 99)
		begin
			tick;
			k++;
		end
		chk_n(int'(k > eff(d3, 6'h01) && k <= eff(d3, 6'h01) + 4), 1);
		chk(clk_enable, 16'h000f);
		tick;
		chk(clk_enable, 16'h00ff);
		tick;
		chk(clk_enable, 16'hffff);
		chk({15'h0, sleep_status}, 16'h0001);
		k = 0;
		while (io_enable !== 1'b1 && k < 99)
		begin
			tick;
			k++;
		end
		chk_n(k, eff(d4, 6'h28));
		chk_awake;
		chk({12'h0, pad_level}, {12'h0, smps_pkg::GPIO_VAL});
		chk({cnt_sleep_exit, cnt_sleep_enter}, {held, held});
		tick;
		held = cnt_value;
		tick;
		chk({8'h0, cnt_value}, {8'h0, held + 8'h01});
	endtask

	// a short request is still carried through sleep and back to awake
	task automatic pulse_cycle;
		@(posedge clk_sys);
		sleep_req <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sleep_req <= 1'b0;
		k = 0;
		while (clk_enable !== 16'h0000 && k < 199)
		begin
			tick;
			k++;
		end
		chk(clk_enable, 16'h0000);
		chk({14'h0, sleep_status, io_enable}, 16'h0002);
		k = 0;
		while (sleep_status !== 1'b0 && k < 199)
		begin
			tick;
			k++;
		end
		chk_awake;
		chk({8'h0, cnt_sleep_exit}, {8'h0, cnt_sleep_enter});
	endtask

	// watchdog
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		errors++;
		end_of_test;
	end

	// main sequence
	initial
	begin
		errors = 0;
		check_count = 0;
		resetn = 1'b0;
		sleep_req = 1'b0;
		{d1, d2, d3, d4} = {6'h01, 6'h0b, 6'h01, 6'h28};
		void'($urandom(32'hb22c5442));
		do_reset;
		sleep_cycle(3);
		@(posedge clk_sys);
		{d1, d2, d3, d4} <= 24'h000000;
		sleep_cycle(1);
		for (it = 0; it < 5; it++)
		begin
			@(posedge clk_sys);
			d1 <= 6'($urandom_range(1, 63));
			d2 <= 6'($urandom_range(11, 63));
			d3 <= 6'($urandom_range(1, 63));
			d4 <= 6'($urandom_range(40, 63));
			repeat ($urandom_range(1, 5)) tick;
			sleep_cycle($urandom_range(1, 30));
		end
		pulse_cycle;
		@(posedge clk_sys);
		sleep_req <= 1'b1;
		repeat ($urandom_range(6, 15)) tick;
		do_reset;
		sleep_cycle(2);
		end_of_test;
	end
endmodule
`default_nettype wire
